// *** src/fspp_params.svh ***
// Purpose: Timing counts, verify codes and limits for the sector protect programmer
// Assumes: 10 MHz clock
// Notes:   Least times round up to whole clock cycles
`ifndef FSPP_PARAMS_SVH
`define FSPP_PARAMS_SVH

`define FSPP_CLK_NS          100
`define FSPP_TST_NS          4000
`define FSPP_TCSP_NS         4000
`define FSPP_TWPP1_NS        150000
`define FSPP_TWPP2_NS        15000000
`define FSPP_TOE_NS          50
`define FSPP_SETUP_CYC       ((`FSPP_TST_NS + `FSPP_CLK_NS - 1) / `FSPP_CLK_NS)
`define FSPP_CSP_CYC         ((`FSPP_TCSP_NS + `FSPP_CLK_NS - 1) / `FSPP_CLK_NS)
`define FSPP_PROT_CYC        ((`FSPP_TWPP1_NS + `FSPP_CLK_NS - 1) / `FSPP_CLK_NS)
`define FSPP_UNPROT_CYC      ((`FSPP_TWPP2_NS + `FSPP_CLK_NS - 1) / `FSPP_CLK_NS)
`define FSPP_READ_CYC        (((`FSPP_TOE_NS + `FSPP_CLK_NS - 1) / `FSPP_CLK_NS) + 3)
`define FSPP_RECOV_CYC       4
`define FSPP_RETRY_MAX       4'ha
`define FSPP_SECTOR_LAST     8'hff
`define FSPP_CODE_PROT       8'h01
`define FSPP_CODE_UNPROT     8'h00
`define FSPP_CNT_W           18

`endif

// *** src/fspp_pkg.sv ***
// Purpose: Types of the sector protect programmer
// Assumes: Constants come from fspp_params.svh
// Notes:   State is one packed struct
`include "fspp_params.svh"

package fspp_pkg;

  typedef enum logic [2:0] {
    FSPP_IDLE  = 3'b000,
    FSPP_SETUP = 3'b001,
    FSPP_PULSE = 3'b010,
    FSPP_RECOV = 3'b011,
    FSPP_READ  = 3'b100,
    FSPP_DONE  = 3'b101
  } fspp_state_e;

  typedef logic [`FSPP_CNT_W-1:0] fspp_cnt_t;

  typedef struct packed {
    fspp_state_e state;
    logic        op_unprot;
    logic        prot_all;
    logic [7:0]  cur;
    logic [7:0]  target;
    fspp_cnt_t   cnt;
    logic [3:0]  tries;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        hv_a9;
    logic        hv_oe;
    logic        a6;
    logic        a1;
    logic        done;
    logic        ok;
    logic [7:0]  dq_meta;
    logic [7:0]  dq_sync;
  } fspp_state_s;

endpackage

// *** src/fspp_programmer.sv ***
// Purpose: Programming-equipment controller for flash sector protect and unprotect
// Assumes: Flash data bus is only read here; elevated_id_voltage switches are external
// Notes:   One protect or unprotect job per start pulse
// What this block does
// - Elevated id voltage held on A9 for the procedure; on output enable except during verify reads.
// - Before first unprotect pulse, every sector is protected first.
// - Verify read pins fixed; flash returns 0x01 protected, 0x00 unprotected.
// - Unprotect write pulse held low at least 15 ms.
// - Output enable and chip select set 4 us before write strobe.
// - Wait 4 us after applying elevated voltage before continuing.
`include "fspp_params.svh"
`timescale 1ns/100ps
`default_nettype none

module fspp_programmer #(
  parameter int PROT_PULSE_CYC   = `FSPP_PROT_CYC,
  parameter int UNPROT_PULSE_CYC = `FSPP_UNPROT_CYC
) (
  input  wire logic        clock_in,
  input  wire logic        sys_rst_in,
  input  wire logic        start_in,
  input  wire logic        unprot_in,
  input  wire logic [7:0]  sector_in,
  input  wire logic [7:0]  dq_in,
  output logic             busy_out,
  output logic             done_out,
  output logic             ok_out,
  output logic             ce_n_out,
  output logic             oe_n_out,
  output logic             we_n_out,
  output logic             reset_n_out,
  output logic [19:0]      addr_out,
  output logic             hv_a9_out,
  output logic             hv_oe_out
);
  import fspp_pkg::*;

  localparam fspp_cnt_t SETUP_N  = fspp_cnt_t'((`FSPP_SETUP_CYC > `FSPP_CSP_CYC) ?
                                                `FSPP_SETUP_CYC : `FSPP_CSP_CYC);
  localparam fspp_cnt_t PROT_N   = fspp_cnt_t'(PROT_PULSE_CYC);
  localparam fspp_cnt_t UNPROT_N = fspp_cnt_t'(UNPROT_PULSE_CYC);
  localparam fspp_cnt_t RECOV_N  = fspp_cnt_t'(`FSPP_RECOV_CYC);
  localparam fspp_cnt_t READ_N   = fspp_cnt_t'(`FSPP_READ_CYC);
  localparam fspp_cnt_t ONE      = fspp_cnt_t'(1);

  fspp_state_s st_reg;
  fspp_state_s st_next;
  logic        unprot_step;
  logic [7:0]  expect_code;

  assign unprot_step = st_reg.op_unprot && !st_reg.prot_all;
  assign expect_code = unprot_step ? `FSPP_CODE_UNPROT : `FSPP_CODE_PROT;

  always_comb begin
    st_next         = st_reg;
    st_next.done    = 1'b0;
    st_next.dq_meta = dq_in;
    st_next.dq_sync = st_reg.dq_meta;
    unique case (st_reg.state)
      FSPP_IDLE: begin
        if (start_in) begin
          st_next.op_unprot = unprot_in;
          st_next.prot_all  = unprot_in;
          st_next.target    = sector_in;
          st_next.cur       = unprot_in ? 8'h00 : sector_in;
          st_next.tries     = 4'h0;
          st_next.ce_n      = 1'b0;
          st_next.hv_a9     = 1'b1;
          st_next.hv_oe     = 1'b1;
          st_next.cnt       = SETUP_N - ONE;
          st_next.state     = FSPP_SETUP;
        end
      end
      FSPP_SETUP: begin
        if (st_reg.cnt == '0) begin
          st_next.we_n  = 1'b0;
          st_next.a6    = unprot_step;
          st_next.a1    = 1'b0;
          st_next.cnt   = (unprot_step ? UNPROT_N : PROT_N) - ONE;
          st_next.state = FSPP_PULSE;
        end else begin
          st_next.cnt = st_reg.cnt - ONE;
        end
      end
      FSPP_PULSE: begin
        if (st_reg.cnt == '0) begin
          st_next.we_n  = 1'b1;
          st_next.cnt   = RECOV_N - ONE;
          st_next.state = FSPP_RECOV;
        end else begin
          st_next.cnt = st_reg.cnt - ONE;
        end
      end
      FSPP_RECOV: begin
        if (st_reg.cnt == '0) begin
          st_next.hv_oe = 1'b0;
          st_next.oe_n  = 1'b0;
          st_next.a6    = unprot_step;
          st_next.a1    = 1'b1;
          st_next.cnt   = READ_N - ONE;
          st_next.state = FSPP_READ;
        end else begin
          st_next.cnt = st_reg.cnt - ONE;
        end
      end
      FSPP_READ: begin
        if (st_reg.cnt == '0) begin
          st_next.oe_n  = 1'b1;
          st_next.hv_oe = 1'b1;
          st_next.a1    = 1'b0;
          st_next.cnt   = SETUP_N - ONE;
          st_next.state = FSPP_SETUP;
          if (st_reg.dq_sync == expect_code) begin
            st_next.tries = 4'h0;
            if (st_reg.prot_all && st_reg.cur != `FSPP_SECTOR_LAST) begin
              st_next.cur = st_reg.cur + 8'h01;
            end else if (st_reg.prot_all) begin
              st_next.prot_all = 1'b0;
              st_next.cur      = st_reg.target;
            end else begin
              st_next.ok    = 1'b1;
              st_next.state = FSPP_DONE;
            end
          end else if (st_reg.tries == `FSPP_RETRY_MAX - 4'h1) begin
            st_next.ok    = 1'b0;
            st_next.state = FSPP_DONE;
          end else begin
            st_next.tries = st_reg.tries + 4'h1;
          end
        end else begin
          st_next.cnt = st_reg.cnt - ONE;
        end
      end
      FSPP_DONE: begin
        st_next.ce_n  = 1'b1;
        st_next.oe_n  = 1'b1;
        st_next.hv_a9 = 1'b0;
        st_next.hv_oe = 1'b0;
        st_next.done  = 1'b1;
        st_next.state = FSPP_IDLE;
      end
      default: begin
        st_next.state = FSPP_IDLE;
      end
    endcase
    if (st_reg.state == FSPP_IDLE && start_in) begin
      st_next.ok = 1'b0;
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_reg       <= '0;
      st_reg.state <= FSPP_IDLE;
      st_reg.ce_n  <= 1'b1;
      st_reg.oe_n  <= 1'b1;
      st_reg.we_n  <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign busy_out    = (st_reg.state != FSPP_IDLE);
  assign done_out    = st_reg.done;
  assign ok_out      = st_reg.ok;
  assign ce_n_out    = st_reg.ce_n;
  assign oe_n_out    = st_reg.oe_n;
  assign we_n_out    = st_reg.we_n;
  assign reset_n_out = 1'b1;
  assign hv_a9_out   = st_reg.hv_a9;
  assign hv_oe_out   = st_reg.hv_oe;
  assign addr_out    = {st_reg.cur, 5'h00, st_reg.a6, 4'h0, st_reg.a1, 1'b0};

  // Helper counters for the checks below
  fspp_cnt_t low_cnt;
  fspp_cnt_t hv_cnt;
  fspp_cnt_t ce_cnt;
  logic      walked;
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      low_cnt <= '0;
      hv_cnt  <= '0;
      ce_cnt  <= '0;
      walked  <= 1'b0;
    end else begin
      low_cnt <= we_n_out ? '0 : low_cnt + ONE;
      hv_cnt  <= (hv_a9_out && hv_oe_out) ? ((hv_cnt == '1) ? hv_cnt : hv_cnt + ONE) : '0;
      ce_cnt  <= !ce_n_out ? ((ce_cnt == '1) ? ce_cnt : ce_cnt + ONE) : '0;
      if (start_in && !busy_out) begin
        walked <= 1'b0;
      end else if (addr_out[19:12] == `FSPP_SECTOR_LAST && !we_n_out && st_reg.prot_all) begin
        walked <= 1'b1;
      end
    end
  end

  hv_in_pulse_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    !we_n_out |-> hv_a9_out && hv_oe_out && !ce_n_out)
    else $error("elevated voltage missing during write pulse");

  pulse_edges_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    $fell(we_n_out) |-> !we_n_out [* 8] ##1 ($past(st_reg.state) == FSPP_PULSE))
    else $error("write pulse shorter than expected");

  verify_pins_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (st_reg.state == FSPP_READ) |-> !ce_n_out && !oe_n_out && we_n_out && reset_n_out
      && hv_a9_out && !hv_oe_out && (addr_out[6] == unprot_step) && addr_out[1] && !addr_out[0])
    else $error("verify read pins wrong");

  unprot_len_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    ($rose(we_n_out) && $past(unprot_step)) |-> ($past(low_cnt) >= UNPROT_N - ONE))
    else $error("unprotect pulse too short");

  ce_setup_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    $fell(we_n_out) |-> ($past(ce_cnt) >= SETUP_N - ONE))
    else $error("chip select setup too short");

  hv_setup_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    $fell(we_n_out) |-> ($past(hv_cnt) >= SETUP_N - ONE))
    else $error("voltage setup too short");

  protect_first_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    ($fell(we_n_out) && unprot_step) |-> walked)
    else $error("unprotect pulse before all sectors protected");

  retry_limit_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (done_out && !ok_out) |-> ($past(st_reg.tries, 2) == `FSPP_RETRY_MAX - 4'h1))
    else $error("failure reported at wrong retry count");

endmodule

`default_nettype wire

// *** sim/fspp_flash_model.sv ***
// Purpose: Behavioural flash for sector protect and unprotect by pins
// Assumes: Pulse widths measured in ns
// Notes:   stuck_in makes write pulses have no effect
`timescale 1ns/100ps
`default_nettype none

module fspp_flash_model #(
  parameter int MIN_PROT_NS   = 150000,
  parameter int MIN_UNPROT_NS = 15000000
) (
  input  wire logic        ce_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        we_n_in,
  input  wire logic        reset_n_in,
  input  wire logic [19:0] addr_in,
  input  wire logic        hv_a9_in,
  input  wire logic        hv_oe_in,
  input  wire logic        stuck_in,
  output logic      [7:0]  dq_out,
  output logic             viol_out
);
  logic [255:0] prot = '0;
  logic [7:0]   last = 8'h5a;
  realtime      t_ce = 0.0;
  realtime      t_a9 = 0.0;
  realtime      t_oe = 0.0;
  realtime      t_we = 0.0;
  wire sel = !ce_n_in && hv_a9_in && hv_oe_in && reset_n_in;
  wire rd  = !ce_n_in && !oe_n_in && !hv_oe_in && hv_a9_in && we_n_in && reset_n_in
             && addr_in[1] && !addr_in[0];
  initial viol_out = 1'b0;
  always @(negedge ce_n_in) t_ce = $realtime;
  always @(posedge hv_a9_in) t_a9 = $realtime;
  always @(posedge hv_oe_in) t_oe = $realtime;
  always @(negedge we_n_in) begin
    if (sel) begin
      if ($realtime - t_ce < 4000 || $realtime - t_oe < 4000) viol_out = 1'b1;
      if ($realtime - t_a9 < 4000) viol_out = 1'b1;
      t_we = $realtime;
    end
  end
  always @(posedge we_n_in) begin
    if (sel && !addr_in[6]) begin
      if ($realtime - t_we >= MIN_PROT_NS && !stuck_in) prot[addr_in[19:12]] = 1'b1;
    end else if (sel) begin
      if (prot != '1) viol_out = 1'b1;
      if ($realtime - t_we < MIN_UNPROT_NS) viol_out = 1'b1;
      else if (!stuck_in) prot = '0;
    end
  end
  always @(posedge rd) last = {7'h0, prot[addr_in[19:12]]};
  assign dq_out = rd ? {7'h0, prot[addr_in[19:12]]} : ~last;
endmodule

`default_nettype wire

// *** sim/test_flash_sector_protect_programmer.sv ***
// Purpose: Self-checking bench of the sector protect programmer
// Assumes: Short protect pulse of 20 cycles and unprotect pulse of 50 cycles
// Notes:   Unprotect job walks all sectors, so the run is long
`timescale 1ns/100ps
`default_nettype none

module test_flash_sector_protect_programmer;
  import fspp_pkg::*;
  localparam int PPULSE = 20;
  localparam int PULSE  = 50;
  localparam int LIMIT  = 40000;
  logic        clock_in   = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        start_in   = 1'b0;
  logic        unprot_in  = 1'b0;
  logic        stuck      = 1'b0;
  logic        ok;
  logic [7:0]  sector_in  = 8'h00;
  logic [7:0]  dq;
  logic        busy, done, ok_o, ce_n, oe_n, we_n, rst_n, hv_a9, hv_oe, viol;
  logic [19:0] addr;
  int          n_fail = 0;
  int          total_checks = 0;
  int          cycles = 0;

  fspp_programmer #(.PROT_PULSE_CYC(PPULSE), .UNPROT_PULSE_CYC(PULSE)) i_dut (.clock_in(clock_in),
    .sys_rst_in(sys_rst_in), .start_in(start_in), .unprot_in(unprot_in),
    .sector_in(sector_in), .dq_in(dq), .busy_out(busy), .done_out(done), .ok_out(ok_o),
    .ce_n_out(ce_n), .oe_n_out(oe_n), .we_n_out(we_n), .reset_n_out(rst_n),
    .addr_out(addr), .hv_a9_out(hv_a9), .hv_oe_out(hv_oe));

  fspp_flash_model #(.MIN_PROT_NS(PPULSE * 100), .MIN_UNPROT_NS(PULSE * 100))
    i_flash (.ce_n_in(ce_n), .oe_n_in(oe_n),
    .we_n_in(we_n), .reset_n_in(rst_n), .addr_in(addr), .hv_a9_in(hv_a9),
    .hv_oe_in(hv_oe), .stuck_in(stuck), .dq_out(dq), .viol_out(viol));

  always #50 clock_in = ~clock_in;

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task finish_test;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clock_in) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_fail++;
      finish_test();
    end
  end

  // Job with a refused second start in its first busy cycle
  task run_job(input logic u, input logic [7:0] s);
    int i;
    @(negedge clock_in);
    start_in  = 1'b1;
    unprot_in = u;
    sector_in = s;
    @(negedge clock_in);
    sector_in = ~s;
    unprot_in = 1'b0;
    check(busy, 1);
    check({ce_n, hv_a9, hv_oe}, 3'b011);
    check(addr[19:12], u ? 8'h00 : s);
    @(negedge clock_in);
    start_in = 1'b0;
    for (i = 0; i < LIMIT; i++) begin
      @(negedge clock_in);
      if (done === 1'b1) break;
    end
    ok = ok_o;
    @(negedge clock_in);
    check(busy, 0);
    check({ce_n, hv_a9}, 2'b10);
  endtask

  task protect_ok(input logic [7:0] s);
    run_job(1'b0, s);
    check(ok, 1);
    check(i_flash.prot[s], 1);
    check(i_flash.prot[~s], 0);
    check(viol, 0);
  endtask

  initial begin
    repeat (16) @(negedge clock_in);
    sys_rst_in = 1'b0;
    check({ce_n, oe_n, we_n, hv_a9, hv_oe, busy, done, ok_o, rst_n}, 9'h1c1);
    check(addr, 0);
    check(|i_flash.prot, 0);
    protect_ok(8'h3c);
    protect_ok(8'hff);
    stuck = 1'b1;
    run_job(1'b0, 8'h05);
    check(ok, 0);
    check(i_flash.prot[8'h05], 0);
    stuck = 1'b0;
    run_job(1'b1, 8'h07);
    check(ok, 1);
    check(|i_flash.prot, 0);
    check(viol, 0);
    finish_test();
  end
endmodule

`default_nettype wire
